// ===== hdl/pps_pkg.sv
// pps_pkg: register map, field layout, bus carriers and select decode for the panel pin select bank.
// assumes a 32-bit AXI4-Lite register bus and one core clock.
package pps_pkg;

  localparam int PPS_ADDR_W = 12;

  // register byte offsets
  localparam logic [PPS_ADDR_W-1:0] PPS_OFF_SELECT = 12'h000;
  localparam logic [PPS_ADDR_W-1:0] PPS_OFF_STATUS = 12'h004;
  localparam logic [PPS_ADDR_W-1:0] PPS_OFF_ACTIVE = 12'h008;

  // select register layout
  localparam logic [31:0] PPS_SELECT_RST  = 32'h0000_0000;
  localparam logic [31:0] PPS_SELECT_MASK = 32'hfffc_ffff;
  localparam int          PPS_FIELD_W     = 2;
  localparam int          PPS_TSIG_N      = 7;
  localparam int          PPS_TSIG_FIRST  = 5;
  localparam int          PPS_TSIG_LSB    = 18;
  localparam int          PPS_PD_N        = 8;
  localparam int          PPS_PD_FIRST    = 16;
  localparam int          PPS_PD_LSB      = 0;
  localparam int          PPS_RSV_LSB     = 16;
  localparam int          PPS_RSV_W       = 2;
  localparam int          PPS_ROUTE_N     = PPS_TSIG_N + PPS_PD_N;

  // select codes
  localparam logic [1:0] PPS_SEL_OFF   = 2'h0;
  localparam logic [1:0] PPS_SEL_FIRST = 2'h1;

  // status bits, write one to clear
  localparam int          PPS_ST_BADSEL  = 0;
  localparam int          PPS_ST_RSVWR   = 1;
  localparam int          PPS_ST_WAKEWR  = 2;
  localparam int          PPS_ST_W       = 3;
  localparam logic [2:0]  PPS_STATUS_RST = 3'h0;

  // bus responses
  localparam logic [1:0] PPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                  awvalid;
    logic [PPS_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [PPS_ADDR_W-1:0] araddr;
    logic                  rready;
  } pps_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pps_axi_rsp_t;

  // only the first-option code hands a pin to the panel; forbidden codes leave it off
  function automatic logic pps_sel_routes(input logic [1:0] sel);
    return sel == PPS_SEL_FIRST;
  endfunction

  function automatic logic pps_sel_forbidden(input logic [1:0] sel);
    return sel[1];
  endfunction

endpackage

// ===== hdl/pps_route_cell.sv
// pps_route_cell: one output pin, choosing between the panel signal and the pin's other function.
// assumes panel and other-function signals are already in the core clock domain.
`timescale 1ns/1ns
module pps_route_cell
  import pps_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // select and sources
  input  wire logic [1:0] i_sel,
  input  wire logic       i_panel,
  input  wire logic       i_other,
  // pin side
  output logic            o_pin,
  output logic            o_active
);

  logic pin_r;
  logic pin_nxt;
  logic act_r;
  logic act_nxt;

  always_comb begin
    act_nxt = pps_sel_routes(i_sel);
    pin_nxt = act_nxt ? i_panel : i_other;
  end

  // registered mux output: a select change cannot glitch the pin
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      act_r <= act_nxt;
    end
  end

  assign o_pin    = pin_r;
  assign o_active = act_r;

endmodule

// ===== hdl/pps_pin_select.sv
// pps_pin_select: panel pin select register bank with an AXI4-Lite slave and fifteen pin routers.
// assumes i_rst is the ordinary synchronous reset and i_wake_rst the deep-standby wake reset.
`timescale 1ns/1ns

module pps_pin_select
  import pps_pkg::*;
(
  // clock and resets
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wake_rst,
  // register bus
  input  wire pps_axi_req_t         i_axi,
  output pps_axi_rsp_t              o_axi,
  // panel controller outputs
  input  wire logic [PPS_TSIG_N-1:0] i_panel_tsig,
  input  wire logic [PPS_PD_N-1:0]   i_panel_pd,
  // other functions sharing the pins
  input  wire logic [PPS_TSIG_N-1:0] i_other_tsig,
  input  wire logic [PPS_PD_N-1:0]   i_other_pd,
  // pins
  output logic [PPS_TSIG_N-1:0]      o_tsig_pin,
  output logic [PPS_PD_N-1:0]        o_pd_pin,
  output logic [PPS_ROUTE_N-1:0]     o_route_active
);

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_HAVE_ADDR,
    WR_HAVE_DATA,
    WR_RESP
  } pps_wr_state_t;

  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } pps_rd_state_t;

  // write channel state
  pps_wr_state_t         wr_state_r;
  pps_wr_state_t         wr_state_nxt;
  logic [PPS_ADDR_W-1:0] waddr_r;
  logic [PPS_ADDR_W-1:0] waddr_nxt;
  logic [31:0]           wdata_r;
  logic [31:0]           wdata_nxt;
  logic [3:0]            wstrb_r;
  logic [3:0]            wstrb_nxt;
  logic [1:0]            bresp_r;
  logic [1:0]            bresp_nxt;

  // read channel state
  pps_rd_state_t         rd_state_r;
  pps_rd_state_t         rd_state_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic [1:0]            rresp_r;
  logic [1:0]            rresp_nxt;

  // register contents
  logic [31:0]           select_r;
  logic [31:0]           select_nxt;
  logic [PPS_ST_W-1:0]   status_r;
  logic [PPS_ST_W-1:0]   status_nxt;

  // commit helpers
  logic                  aw_take;
  logic                  w_take;
  logic                  commit;
  logic [PPS_ADDR_W-1:0] c_addr;
  logic [31:0]           c_data;
  logic [3:0]            c_strb;
  logic [31:0]           c_mask;
  logic [31:0]           c_merged;
  logic                  c_badsel;
  logic                  c_rsvwr;
  logic [PPS_ROUTE_N-1:0] route_active;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic addr_mapped(input logic [PPS_ADDR_W-1:0] a);
    return (a == PPS_OFF_SELECT) || (a == PPS_OFF_STATUS) || (a == PPS_OFF_ACTIVE);
  endfunction

  // handshake outputs are combinational from state
  assign aw_take = i_axi.awvalid && ((wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_DATA));
  assign w_take  = i_axi.wvalid && ((wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_ADDR));

  always_comb begin
    commit = 1'b0;
    case (wr_state_r)
      WR_IDLE:      commit = aw_take && w_take;
      WR_HAVE_ADDR: commit = w_take;
      WR_HAVE_DATA: commit = aw_take;
      WR_RESP:      commit = 1'b0;
      default:      commit = 1'b0;
    endcase
  end

  // address and data may arrive in either order; use whichever is live
  always_comb begin
    c_addr = (wr_state_r == WR_HAVE_ADDR) ? waddr_r : i_axi.awaddr;
    c_data = (wr_state_r == WR_HAVE_DATA) ? wdata_r : i_axi.wdata;
    c_strb = (wr_state_r == WR_HAVE_DATA) ? wstrb_r : i_axi.wstrb;
    c_mask = strb_mask(c_strb);
    c_merged = ((select_r & ~c_mask) | (c_data & c_mask)) & PPS_SELECT_MASK;
    c_rsvwr = |(c_data[PPS_RSV_LSB +: PPS_RSV_W] & c_mask[PPS_RSV_LSB +: PPS_RSV_W]);
    c_badsel = 1'b0;
    for (int f = 0; f < 16; f++) begin
      if (f != PPS_RSV_LSB / PPS_FIELD_W) begin
        if (c_mask[f*2] && pps_sel_forbidden(c_data[f*2 +: 2])) begin
          c_badsel = 1'b1;
        end
      end
    end
  end

  // write channel next state
  always_comb begin
    wr_state_nxt = wr_state_r;
    waddr_nxt    = waddr_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    bresp_nxt    = bresp_r;
    case (wr_state_r)
      WR_IDLE: begin
        if (commit) begin
          wr_state_nxt = WR_RESP;
        end else if (aw_take) begin
          wr_state_nxt = WR_HAVE_ADDR;
          waddr_nxt    = i_axi.awaddr;
        end else if (w_take) begin
          wr_state_nxt = WR_HAVE_DATA;
          wdata_nxt    = i_axi.wdata;
          wstrb_nxt    = i_axi.wstrb;
        end
      end
      WR_HAVE_ADDR: begin
        if (commit) begin
          wr_state_nxt = WR_RESP;
        end
      end
      WR_HAVE_DATA: begin
        if (commit) begin
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (i_axi.bready) begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default: begin
        wr_state_nxt = WR_IDLE;
      end
    endcase
    if (commit) begin
      bresp_nxt = (addr_mapped(c_addr) && !i_wake_rst) ? PPS_RESP_OKAY : PPS_RESP_SLVERR;
    end
  end

  // register contents next state
  always_comb begin
    select_nxt = select_r;
    status_nxt = status_r;
    if (commit && i_wake_rst) begin
      // writes during wake reset are refused so the stored routing survives it
      status_nxt[PPS_ST_WAKEWR] = 1'b1;
    end else if (commit) begin
      case (c_addr)
        PPS_OFF_SELECT: begin
          // forbidden codes are stored as written so a read shows them; they route nothing
          select_nxt = c_merged;
          status_nxt[PPS_ST_BADSEL] = status_r[PPS_ST_BADSEL] | c_badsel;
          status_nxt[PPS_ST_RSVWR]  = status_r[PPS_ST_RSVWR] | c_rsvwr;
        end
        PPS_OFF_STATUS: begin
          status_nxt = status_r & ~(c_data[PPS_ST_W-1:0] & c_mask[PPS_ST_W-1:0]);
        end
        default: begin
          select_nxt = select_r;
        end
      endcase
    end
  end

  // read channel next state; reads have no side effects
  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (i_axi.arvalid) begin
          rd_state_nxt = RD_RESP;
          rresp_nxt    = PPS_RESP_OKAY;
          case (i_axi.araddr)
            PPS_OFF_SELECT: rdata_nxt = select_r & PPS_SELECT_MASK;
            PPS_OFF_STATUS: rdata_nxt = {{(32-PPS_ST_W){1'b0}}, status_r};
            PPS_OFF_ACTIVE: rdata_nxt = {{(32-PPS_ROUTE_N){1'b0}}, route_active};
            default: begin
              rdata_nxt = 32'h0000_0000;
              rresp_nxt = PPS_RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (i_axi.rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  // bus channel registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_state_r <= WR_IDLE;
      waddr_r    <= '0;
      wdata_r    <= 32'h0000_0000;
      wstrb_r    <= 4'h0;
      bresp_r    <= PPS_RESP_OKAY;
      rd_state_r <= RD_IDLE;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= PPS_RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      waddr_r    <= waddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bresp_r    <= bresp_nxt;
      rd_state_r <= rd_state_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // only the ordinary reset clears the bank; the wake reset is not wired here
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      select_r <= PPS_SELECT_RST;
      status_r <= PPS_STATUS_RST;
    end else begin
      select_r <= select_nxt;
      status_r <= status_nxt;
    end
  end

  // pin routers, timing signals above the reserved pair, pixel bits below
  for (genvar t = 0; t < PPS_TSIG_N; t++) begin : g_tsig
    pps_route_cell u_cell (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_sel      (select_r[PPS_TSIG_LSB + t*PPS_FIELD_W +: PPS_FIELD_W]),
      .i_panel    (i_panel_tsig[t]),
      .i_other    (i_other_tsig[t]),
      .o_pin      (o_tsig_pin[t]),
      .o_active   (route_active[PPS_PD_N + t])
    );
  end

  for (genvar p = 0; p < PPS_PD_N; p++) begin : g_pd
    pps_route_cell u_cell (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_sel      (select_r[PPS_PD_LSB + p*PPS_FIELD_W +: PPS_FIELD_W]),
      .i_panel    (i_panel_pd[p]),
      .i_other    (i_other_pd[p]),
      .o_pin      (o_pd_pin[p]),
      .o_active   (route_active[p])
    );
  end

  assign o_route_active = route_active;

  always_comb begin
    o_axi.awready = (wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_DATA);
    o_axi.wready  = (wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_ADDR);
    o_axi.bvalid  = (wr_state_r == WR_RESP);
    o_axi.bresp   = bresp_r;
    o_axi.arready = (rd_state_r == RD_IDLE);
    o_axi.rvalid  = (rd_state_r == RD_RESP);
    o_axi.rdata   = rdata_r;
    o_axi.rresp   = rresp_r;
  end

endmodule

// ===== sim/pps_pin_select_props.sv
// pps_pin_select_props: port-level checks of the panel pin select bank.
// assumes one core clock and the synchronous active-high i_rst.
`timescale 1ns/1ns
module pps_pin_select_props
  import pps_pkg::*;
(
  // clock and resets
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire logic                   i_wake_rst,
  // register bus
  input wire pps_axi_req_t           i_axi,
  input wire pps_axi_rsp_t           o_axi,
  // sources and pins
  input wire logic [PPS_TSIG_N-1:0]  i_panel_tsig,
  input wire logic [PPS_PD_N-1:0]    i_panel_pd,
  input wire logic [PPS_TSIG_N-1:0]  i_other_tsig,
  input wire logic [PPS_PD_N-1:0]    i_other_pd,
  input wire logic [PPS_TSIG_N-1:0]  o_tsig_pin,
  input wire logic [PPS_PD_N-1:0]    o_pd_pin,
  input wire logic [PPS_ROUTE_N-1:0] o_route_active
);
  // same bit order as o_route_active: timing signals above pixel bits
  wire [14:0] pan = {i_panel_tsig, i_panel_pd};
  wire [14:0] oth = {i_other_tsig, i_other_pd};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_pin_mux;
    !$past(i_rst) |-> {o_tsig_pin, o_pd_pin} == ((o_route_active & $past(pan)) | (~o_route_active & $past(oth)));
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin source wrong");
  property p_reset_off; $past(i_rst) |-> o_route_active == 15'h0000; endproperty
  a_reset_off: assert property (p_reset_off) else $error("route not off after reset");
  // routing may only move one cycle after a write answer appears
  property p_route_hold; !$rose(o_axi.bvalid) |=> $stable(o_route_active); endproperty
  a_route_hold: assert property (p_route_hold) else $error("route changed without write");
  property p_wake_keep; $past(i_wake_rst) |=> $stable(o_route_active); endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("route changed in wake reset");
  property p_rsv_zero; o_axi.rvalid |-> o_axi.rdata[17:16] == 2'h0; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
  property p_rdata_hold; o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_wr_answer;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |=> o_axi.bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; i_axi.arvalid && o_axi.arready |=> o_axi.rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  c_write: cover property ($rose(o_axi.bvalid));
  c_read: cover property ($rose(o_axi.rvalid));
  c_wake: cover property (i_wake_rst && o_axi.bvalid && o_axi.bresp == PPS_RESP_SLVERR);
endmodule

bind pps_pin_select pps_pin_select_props u_props (.i_core_clk, .i_rst, .i_wake_rst, .i_axi, .o_axi,
  .i_panel_tsig, .i_panel_pd, .i_other_tsig, .i_other_pd, .o_tsig_pin, .o_pd_pin, .o_route_active);

// ===== sim/pps_panel_model.sv
// pps_panel_model: panel controller outputs and the pins' other functions.
// assumes the core clock; sources change every cycle so a stale or wrong route shows.
`timescale 1ns/1ns
module pps_panel_model
  import pps_pkg::*;
(
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  // sources
  output logic [PPS_TSIG_N-1:0]      o_panel_tsig,
  output logic [PPS_PD_N-1:0]        o_panel_pd,
  output logic [PPS_TSIG_N-1:0]      o_other_tsig,
  output logic [PPS_PD_N-1:0]        o_other_pd
);
  logic [15:0] pat_r;
  logic [15:0] pat_nxt;
  always_comb begin
    pat_nxt = {pat_r[14:0], pat_r[15] ^ pat_r[13] ^ pat_r[12] ^ pat_r[10]};
    // other function is the inverse, so every pin differs between its two sources
    o_panel_tsig = pat_r[6:0];
    o_panel_pd = pat_r[15:8];
    o_other_tsig = ~pat_r[6:0];
    o_other_pd = ~pat_r[15:8];
  end
  always_ff @(posedge i_core_clk) begin
    pat_r <= i_rst ? 16'hace1 : pat_nxt;
  end
endmodule

// ===== sim/pps_pin_select_bench.sv
// pps_pin_select_bench: self-checking bench for the panel pin select bank.
// assumes the checker is bound in and the panel model drives every source input.
`timescale 1ns/1ns
module pps_pin_select_bench
  import pps_pkg::*;
();
  typedef struct packed {logic [31:0] d; logic [31:0] rb; logic [14:0] act;} pps_row_t;
  logic                  i_core_clk, i_rst, i_wake_rst;
  pps_axi_req_t          i_axi;
  pps_axi_rsp_t          o_axi;
  logic [PPS_TSIG_N-1:0] i_panel_tsig, i_other_tsig, o_tsig_pin;
  logic [PPS_PD_N-1:0]   i_panel_pd, i_other_pd, o_pd_pin;
  logic [14:0]           o_route_active;
  int                    bad_count = 0;
  int                    n_compared = 0;
  pps_row_t              rows [5] = '{
    '{32'h4000_0001, 32'h4000_0001, 15'h4001},
    '{32'h0004_4000, 32'h0004_4000, 15'h0180},
    '{32'h0010_0000, 32'h0010_0000, 15'h0200},
    '{32'h1000_0100, 32'h1000_0100, 15'h2010},
    '{32'h5554_5555, 32'h5554_5555, 15'h7fff}};

  pps_pin_select DUT (.i_core_clk, .i_rst, .i_wake_rst, .i_axi, .o_axi, .i_panel_tsig, .i_panel_pd,
    .i_other_tsig, .i_other_pd, .o_tsig_pin, .o_pd_pin, .o_route_active);
  pps_panel_model u_panel (.i_core_clk, .i_rst, .o_panel_tsig(i_panel_tsig), .o_panel_pd(i_panel_pd),
    .o_other_tsig(i_other_tsig), .o_other_pd(i_other_pd));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo;
    bad_count++;
    $display("wrong value at %0t: bus answer never came", $time);
    end_sim;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_core_clk);
    i_axi <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1, default:'0};
    repeat (40) begin
      @(posedge i_core_clk);
      if (o_axi.awready) i_axi.awvalid <= 1'b0;
      if (o_axi.wready) i_axi.wvalid <= 1'b0;
      if (o_axi.bvalid) begin
        i_axi.bready <= 1'b0;
        chk({30'h0, o_axi.bresp}, {30'h0, er});
        return;
      end
    end
    tmo;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_core_clk);
    i_axi <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
    repeat (40) begin
      @(posedge i_core_clk);
      if (o_axi.arready) i_axi.arvalid <= 1'b0;
      if (o_axi.rvalid) begin
        i_axi.rready <= 1'b0;
        chk(o_axi.rdata, ed);
        chk({30'h0, o_axi.rresp}, {30'h0, er});
        return;
      end
    end
    tmo;
  endtask

  // pins settle one edge after the sources they are checked against
  task automatic pchk(input logic [14:0] act);
    logic [14:0] pan;
    logic [14:0] oth;
    @(posedge i_core_clk);
    #1;
    pan = {i_panel_tsig, i_panel_pd};
    oth = {i_other_tsig, i_other_pd};
    @(posedge i_core_clk);
    #1;
    chk({17'h0, o_route_active}, {17'h0, act});
    chk({17'h0, o_tsig_pin, o_pd_pin}, {17'h0, (act & pan) | (~act & oth)});
  endtask

  initial begin
    i_rst = 1'b1;
    i_wake_rst = 1'b0;
    i_axi = '0;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(PPS_OFF_SELECT, 32'h0, PPS_RESP_OKAY);
    pchk(15'h0000);
    foreach (rows[k]) begin
      wr(PPS_OFF_SELECT, rows[k].d, PPS_RESP_OKAY);
      rd(PPS_OFF_SELECT, rows[k].rb, PPS_RESP_OKAY);
      pchk(rows[k].act);
    end
    @(posedge i_core_clk);
    i_wake_rst <= 1'b1;
    wr(PPS_OFF_SELECT, 32'h0, PPS_RESP_SLVERR);
    rd(PPS_OFF_SELECT, 32'h5554_5555, PPS_RESP_OKAY);
    pchk(15'h7fff);
    @(posedge i_core_clk);
    i_wake_rst <= 1'b0;
    // refused wake write leaves its trace in status; the live route word ignores writes
    rd(PPS_OFF_ACTIVE, 32'h0000_7fff, PPS_RESP_OKAY);
    wr(PPS_OFF_ACTIVE, 32'h0, PPS_RESP_OKAY);
    rd(PPS_OFF_ACTIVE, 32'h0000_7fff, PPS_RESP_OKAY);
    rd(PPS_OFF_STATUS, 32'h0000_0004, PPS_RESP_OKAY);
    wr(PPS_OFF_STATUS, 32'h0000_0007, PPS_RESP_OKAY);
    rd(PPS_OFF_STATUS, 32'h0, PPS_RESP_OKAY);
    wr(12'hffc, 32'h0, PPS_RESP_SLVERR);
    rd(12'hffc, 32'h0, PPS_RESP_SLVERR);
    rd(PPS_OFF_SELECT, 32'h5554_5555, PPS_RESP_OKAY);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(PPS_OFF_SELECT, 32'h0, PPS_RESP_OKAY);
    pchk(15'h0000);
    end_sim;
  end
endmodule
